// >>> fault_history_monitor.sv
// module: fault history snapshot monitor with apb register access
`timescale 1ns/10ps
module fault_history_monitor
    import fault_history_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // fault event from drive logic, same clock
    input  wire logic        fault_valid,
    input  wire logic [15:0] fault_code,
    // live measurements, same clock
    input  wire live_meas_t  live_meas,
    input  wire logic [15:0] speed_fine,
    // position counting, same clock
    input  wire position_step_t pos_step,
    // digital i/o pins
    input  wire logic [4:0]  digital_input_pins,
    input  wire logic [1:0]  digital_output_levels
);

    // =========================================================
    // state
    typedef struct packed {
        logic [3:0]  sel;
        logic [31:0] deviation;
        logic [2:0][4:0] di_sync;
        logic [4:0]  di_level;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
    } mon_t;

    mon_t      s_q;
    mon_t      s_d;
    snapshot_t sel_entry;
    snapshot_t new_entry;

    function automatic logic [31:0] zext16(input logic [15:0] v);
        return {16'h0000, v};
    endfunction : zext16

    // =========================================================
    // snapshot assembly: every field from this same cycle except inputs, which come from the registered filtered pin level
    always_comb begin
        new_entry            = '0;
        new_entry.code       = fault_code;
        new_entry.time_stamp = live_meas.run_time;
        new_entry.speed      = live_meas.speed;
        new_entry.cur_u      = live_meas.cur_u;
        new_entry.cur_v      = live_meas.cur_v;
        new_entry.bus_volt   = live_meas.bus_volt;
        new_entry.inputs     = s_q.di_level;
        new_entry.outputs    = digital_output_levels;
    end

    fault_history_store #(
        .DEPTH (HIST_DEPTH)
    ) u_store (
        .pclk      (pclk),
        .presetn   (presetn),
        .capture   (fault_valid),
        .new_entry (new_entry),
        .sel       (s_q.sel),
        .sel_entry (sel_entry)
    );

    // =========================================================
    // next state
    logic        setup;
    logic        access;
    logic [31:0] dev_next;

    always_comb begin
        s_d      = s_q;
        setup    = psel && !penable;
        access   = psel && penable;
        dev_next = s_q.deviation;

        // input pins: three stages, accept once stages two and three agree
        s_d.di_sync[0] = digital_input_pins;
        s_d.di_sync[1] = s_q.di_sync[0];
        s_d.di_sync[2] = s_q.di_sync[1];
        for (int i = 0; i < DI_COUNT; i++) begin
            if (s_q.di_sync[1][i] == s_q.di_sync[2][i]) begin
                s_d.di_level[i] = s_q.di_sync[2][i];
            end
        end

        // deviation: commanded minus feedback, wraps in two's complement
        if (pos_step.cmd_valid) begin
            dev_next = dev_next + pos_step.cmd_delta;
        end
        if (pos_step.fb_valid) begin
            dev_next = dev_next - pos_step.fb_delta;
        end
        s_d.deviation = dev_next;

        // apb: one wait-free access phase, answer registered at setup
        s_d.ready  = 1'b0;
        s_d.slverr = 1'b0;
        if (setup) begin
            s_d.ready = 1'b1;
            s_d.rdata = '0;
            case (paddr)
                OFS_SELECT:    s_d.rdata = {28'h0, s_q.sel};
                OFS_CODE:      s_d.rdata = zext16(sel_entry.code);
                OFS_TIME:      s_d.rdata = sel_entry.time_stamp;
                OFS_SPEED:     s_d.rdata = zext16(sel_entry.speed);
                OFS_CUR_U:     s_d.rdata = zext16(sel_entry.cur_u);
                OFS_CUR_V:     s_d.rdata = zext16(sel_entry.cur_v);
                OFS_BUS_VOLT:  s_d.rdata = zext16(sel_entry.bus_volt);
                OFS_INPUTS:    s_d.rdata = {27'h0, sel_entry.inputs};
                OFS_OUTPUTS:   s_d.rdata = {30'h0, sel_entry.outputs};
                OFS_DEVIATION: s_d.rdata = s_q.deviation;
                OFS_FINE_SPD:  s_d.rdata = zext16(speed_fine);
                OFS_LIVE_IO: begin
                    s_d.rdata[LIVE_DI_LSB +: DI_COUNT] = s_q.di_level;
                    s_d.rdata[LIVE_DO_LSB +: DO_COUNT] =
                        digital_output_levels;
                end
                default:       s_d.slverr = 1'b1;
            endcase
            // writes to read-only words are refused with an error
            if (pwrite && paddr != OFS_SELECT) begin
                s_d.slverr = 1'b1;
            end
        end

        // selector write takes effect at the completing edge only
        if (access && s_q.ready && pwrite && paddr == OFS_SELECT) begin
            if (pwdata <= 32'(SEL_MAX)) begin
                s_d.sel = pwdata[3:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q           <= '0;
            s_q.sel       <= RST_SELECT;
            s_q.deviation <= RST_DEVIATION;
        end else begin
            s_q <= s_d;
        end
    end

    // =========================================================
    // outputs straight from flops
    assign prdata  = s_q.rdata;
    assign pready  = s_q.ready;
    assign pslverr = s_q.slverr;

endmodule : fault_history_monitor

// >>> fault_history_pkg.sv
// package: register map, field layouts and snapshot types of the fault monitor
package fault_history_pkg;

    // =========================================================
    // sizes
    localparam int unsigned HIST_DEPTH = 10;
    localparam int unsigned SEL_MAX    = 9;
    localparam int unsigned DI_COUNT   = 5;
    localparam int unsigned DO_COUNT   = 2;

    // =========================================================
    // register byte offsets
    localparam logic [7:0] OFS_SELECT    = 8'h00;
    localparam logic [7:0] OFS_CODE      = 8'h04;
    localparam logic [7:0] OFS_TIME      = 8'h08;
    localparam logic [7:0] OFS_SPEED     = 8'h0c;
    localparam logic [7:0] OFS_CUR_U     = 8'h10;
    localparam logic [7:0] OFS_CUR_V     = 8'h14;
    localparam logic [7:0] OFS_BUS_VOLT  = 8'h18;
    localparam logic [7:0] OFS_INPUTS    = 8'h1c;
    localparam logic [7:0] OFS_OUTPUTS   = 8'h20;
    localparam logic [7:0] OFS_DEVIATION = 8'h24;
    localparam logic [7:0] OFS_FINE_SPD  = 8'h28;
    localparam logic [7:0] OFS_LIVE_IO   = 8'h2c;

    // =========================================================
    // reset values
    localparam logic [3:0]  RST_SELECT    = 4'h0;
    localparam logic [31:0] RST_DEVIATION = 32'h0000_0000;
    localparam logic [3:0]  RST_COUNT     = 4'h0;

    // live i/o status register: inputs in bits 4:0, outputs in 9:8
    localparam int unsigned LIVE_DI_LSB = 0;
    localparam int unsigned LIVE_DO_LSB = 8;

    // =========================================================
    // one history entry
    typedef struct packed {
        logic [15:0] code;
        logic [31:0] time_stamp;
        logic [15:0] speed;
        logic [15:0] cur_u;
        logic [15:0] cur_v;
        logic [15:0] bus_volt;
        logic [4:0]  inputs;
        logic [1:0]  outputs;
    } snapshot_t;

    // live values sampled when a fault is detected
    typedef struct packed {
        logic [31:0] run_time;
        logic [15:0] speed;
        logic [15:0] cur_u;
        logic [15:0] cur_v;
        logic [15:0] bus_volt;
    } live_meas_t;

    // position counting increments for one cycle
    typedef struct packed {
        logic        cmd_valid;
        logic [31:0] cmd_delta;
        logic        fb_valid;
        logic [31:0] fb_delta;
    } position_step_t;

endpackage : fault_history_pkg

// >>> fault_history_store.sv
// module: ten-deep shifting fault history with selected-entry read port
`timescale 1ns/10ps
module fault_history_store
    import fault_history_pkg::*;
#(
    parameter int unsigned DEPTH = HIST_DEPTH
) (
    // clock and reset
    input  wire logic      pclk,
    input  wire logic      presetn,
    // capture side
    input  wire logic      capture,
    input  wire snapshot_t new_entry,
    // read side
    input  wire logic [3:0] sel,
    output snapshot_t      sel_entry
);

    typedef struct packed {
        snapshot_t [DEPTH-1:0] entry;
        logic      [3:0]       count;
    } store_t;

    store_t st_q;
    store_t st_d;

    // =========================================================
    // shift on capture
    always_comb begin
        st_d = st_q;
        if (capture) begin
            for (int i = int'(DEPTH) - 1; i > 0; i--) begin
                st_d.entry[i] = st_q.entry[i-1];
            end
            st_d.entry[0] = new_entry;
            if (st_q.count < 4'(DEPTH)) begin
                st_d.count = st_q.count + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // =========================================================
    // an unfilled slot reads as all zero
    always_comb begin
        sel_entry = '0;
        if (sel < st_q.count && 32'(sel) < DEPTH) begin
            sel_entry = st_q.entry[sel];
        end
    end

endmodule : fault_history_store

// >>> fault_history_monitor_sva.sv
// checker: apb timing and read-path properties of the fault monitor
`timescale 1ns/10ps
module fault_history_monitor_chk (
    // =====================================================
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // live speed
    input wire logic [15:0] speed_fine
);
    wire req_setup = psel && !penable;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_ready_next: assert property (req_setup |=> pready)
        else $error("pready missing after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_ready_cause: assert property (pready |-> $past(req_setup))
        else $error("pready without setup");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_ro_write: assert property (
        req_setup && pwrite && paddr != 8'h00 |=> pslverr)
        else $error("write to read-only place accepted");
    chk_unmapped_read: assert property (
        req_setup && paddr > 8'h2c |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    chk_sel_range: assert property (
        req_setup && !pwrite && paddr == 8'h00 |=> prdata <= 32'h9)
        else $error("selector outside 0 to 9");
    chk_fine_speed: assert property (
        req_setup && !pwrite && paddr == 8'h28
        |=> prdata == {16'h0, $past(speed_fine)})
        else $error("fine speed read mismatch");
endmodule : fault_history_monitor_chk

bind fault_history_monitor fault_history_monitor_chk u_chk (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .speed_fine);

// >>> fault_history_monitor_tb.sv
// testbench: register access, fault capture and history order
`timescale 1ns/10ps
module fault_history_monitor_tb import fault_history_pkg::*;;
    logic           pclk, presetn, psel, penable, pwrite, fault_valid;
    logic           pready, pslverr, e;
    logic [7:0]     paddr;
    logic [31:0]    pwdata, prdata, r;
    logic [15:0]    fault_code, speed_fine;
    logic [4:0]     digital_input_pins;
    logic [1:0]     digital_output_levels;
    live_meas_t     live_meas;
    position_step_t pos_step;
    int             bad_count = 0;
    int             tests_run = 0;

    fault_history_monitor dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .fault_valid,
        .fault_code, .live_meas, .speed_fine, .pos_step,
        .digital_input_pins, .digital_output_levels);

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // =====================================================
    // shared tasks
    task automatic chk(string name, logic [31:0] got, logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic test_done();
        if (bad_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pready", {31'h0, pready}, 32'h1);
    endtask : xfer

    task automatic rd(logic [7:0] a, logic [31:0] x, string name);
        xfer(1'b0, a, 32'h0);
        chk(name, r, x);
        chk("pslverr", {31'h0, e}, 32'h0);
    endtask : rd

    // field j of history entry for the n-th fault injected
    function automatic logic [31:0] expv(int j, int n);
        case (j)
            1: return 32'h0100 + 32'(n);
            2: return 32'h0001_0000 + 32'(n);
            7: return 32'(n % 32);
            8: return 32'(n % 4);
            default: return 32'(j * 256 + n);
        endcase
    endfunction : expv

    task automatic inject(int n);
        digital_input_pins <= 5'(n);
        digital_output_levels <= 2'(n);
        // pins pass a synchroniser, so let them settle first
        repeat (5) @(posedge pclk);
        fault_valid <= 1'b1;
        fault_code <= 16'(expv(1, n));
        live_meas <= {expv(2, n), 16'(expv(3, n)), 16'(expv(4, n)),
                      16'(expv(5, n)), 16'(expv(6, n))};
        @(posedge pclk);
        fault_valid <= 1'b0;
        live_meas <= '1;
    endtask : inject

    // =====================================================
    // scenarios
    task automatic empty_history();
        for (int s = 0; s < 10; s++) begin
            xfer(1'b1, 8'h00, 32'(s));
            rd(8'h00, 32'(s), "select");
            for (int j = 1; j < 9; j++) begin
                rd(8'(4 * j), 32'h0, "empty");
            end
        end
    endtask : empty_history

    task automatic misc_regs();
        xfer(1'b1, 8'h04, 32'h1);
        chk("ro write", {31'h0, e}, 32'h1);
        xfer(1'b0, 8'h30, 32'h0);
        chk("unmapped err", {31'h0, e}, 32'h1);
        chk("unmapped data", r, 32'h0);
        pos_step <= {1'b1, 32'd5, 1'b1, 32'd8};
        @(posedge pclk);
        pos_step <= '0;
        rd(8'h24, 32'hffff_fffd, "deviation");
        pos_step <= {1'b1, 32'd10, 1'b0, 32'd0};
        @(posedge pclk);
        pos_step <= '0;
        rd(8'h24, 32'd7, "deviation");
        speed_fine <= 16'd30000;
        digital_input_pins <= 5'b11110;
        digital_output_levels <= 2'b10;
        repeat (5) @(posedge pclk);
        rd(8'h28, 32'd30000, "fine speed");
        rd(8'h2c, 32'h0000_021e, "live io");
    endtask : misc_regs

    task automatic history_order();
        for (int n = 1; n <= 11; n++) begin
            inject(n);
        end
        for (int s = 0; s < 10; s++) begin
            xfer(1'b1, 8'h00, 32'(s));
            for (int j = 1; j < 9; j++) begin
                rd(8'(4 * j), expv(j, 11 - s), "entry");
            end
        end
        xfer(1'b1, 8'h00, 32'ha);
        rd(8'h00, 32'h9, "select kept");
    endtask : history_order

    // a reset in mid-run must empty the history and clear the counter
    task automatic reset_clears();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 32'h0, "select reset");
        rd(8'h04, 32'h0, "code reset");
        rd(8'h24, 32'h0, "deviation reset");
    endtask : reset_clears

    initial begin
        {presetn, psel, penable, pwrite, fault_valid} = '0;
        {paddr, pwdata, fault_code, speed_fine} = '0;
        {live_meas, pos_step} = '0;
        {digital_input_pins, digital_output_levels} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h00, 32'h0, "select reset");
        empty_history();
        misc_regs();
        history_order();
        reset_clears();
        test_done();
    end

    initial begin
        #100000;
        bad_count++;
        test_done();
    end
endmodule : fault_history_monitor_tb
